// >>> cmdlist_handshake.sv
// command list address handshake controller behind the bit-addressed port
`default_nettype none
module cmdlist_handshake #(
    parameter logic [cmdlist_pkg::CRU_AW-1:0] BLOCK_BASE = cmdlist_pkg::BLOCK_BASE_DEF,
    parameter int unsigned SELFTEST_CYCLES = cmdlist_pkg::SELFTEST_CYC
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [cmdlist_pkg::CRU_AW-1:0] cru_addr,
    input wire logic cru_wr,
    input wire logic cru_wdata,
    output logic cru_rdata,
    output logic controller_irq_line,
    output logic list_start,
    output logic [cmdlist_pkg::LIST_AW-1:0] list_addr,
    input wire logic exec_done,
    input wire logic dflt_load,
    input wire logic [cmdlist_pkg::LIST_AW-1:0] dflt_addr_in,
    input wire logic host_irq_event,
    output logic host_irq,
    output logic busy,
    output logic ctrl_in_reset
);
    import cmdlist_pkg::*;
    // -----------------------------------------------------------------
    // declarations
    // -----------------------------------------------------------------
    logic [7:0] addr_byte; // byte on output positions 0-7
    logic first_flag; // first-byte flag position
    logic request_strobe; // host request strobe
    logic irq_enable; // host interrupt enable
    logic ctrl_reset; // hard reset bit from the host
    ctl_state_t state_ff; // controller sequence state
    logic ack_ff; // byte-taken acknowledge
    logic issued_ff; // host interrupt issued flag
    logic [1:0] cnt_ff; // bytes still expected
    logic [7:0] byte0_ff; // first received byte
    logic [7:0] byte1_ff; // second received byte
    logic [7:0] byte2_ff; // third received byte
    logic [LIST_AW-1:0] dflt_ff; // stored default list address
    logic dflt_valid_ff; // a default address was stored
    logic start_ff; // one-cycle start pulse
    logic [LIST_AW-1:0] laddr_ff; // address handed to the executor
    logic [31:0] test_cnt_ff; // self-test cycles left
    logic both_high; // strobe and flag both high
    logic both_low; // strobe and flag both low
    // -----------------------------------------------------------------
    // register port
    // -----------------------------------------------------------------
    cru_bit_port #(
        .BLOCK_BASE(BLOCK_BASE)
    ) u_port (
        .mclk(mclk),
        .rstn(rstn),
        .cru_addr(cru_addr),
        .cru_wr(cru_wr),
        .cru_wdata(cru_wdata),
        .st_ack(ack_ff),
        .st_busy(busy),
        .st_issued(issued_ff),
        .cru_rdata(cru_rdata),
        .addr_byte(addr_byte),
        .first_flag(first_flag),
        .strobe(request_strobe),
        .irq_enable(irq_enable),
        .ctrl_reset(ctrl_reset)
    );
    assign both_high = request_strobe && first_flag;
    assign both_low = !request_strobe && !first_flag;
    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    // strobe level is the interrupt to the internal processor
    assign controller_irq_line = request_strobe;
    assign busy = (state_ff != ST_IDLE);
    assign ctrl_in_reset = ctrl_reset;
    assign list_start = start_ff;
    assign list_addr = laddr_ff;
    assign host_irq = issued_ff;
    // -----------------------------------------------------------------
    // self-test timer
    // -----------------------------------------------------------------
    // held loaded during reset, runs down after release
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            test_cnt_ff <= SELFTEST_CYCLES;
        end else if (ctrl_reset) begin
            test_cnt_ff <= SELFTEST_CYCLES;
        end else if (state_ff == ST_TEST && test_cnt_ff != 32'h0000_0000) begin
            test_cnt_ff <= test_cnt_ff - 32'h0000_0001;
        end
    end
    // -----------------------------------------------------------------
    // sequence state
    // -----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= ST_TEST;
        end else if (ctrl_reset) begin
            // hard reset holds the controller in self-test
            state_ff <= ST_TEST;
        end else begin
            unique case (state_ff)
                ST_TEST: begin
                    if (test_cnt_ff == 32'h0000_0000) begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    // stored default address skips the bytes
                    if (both_high) begin
                        state_ff <= dflt_valid_ff ? ST_DFLT : ST_ACKED;
                    end
                end
                ST_ACKED: begin
                    if (!request_strobe) begin
                        state_ff <= (cnt_ff == 2'h1) ? ST_EXEC : ST_NEXT;
                    end
                end
                ST_NEXT: begin
                    if (request_strobe) begin
                        state_ff <= ST_ACKED;
                    end
                end
                ST_DFLT: begin
                    // wait for both strobe and flag low
                    if (both_low) begin
                        state_ff <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (exec_done) begin
                        state_ff <= ST_IDLE;
                    end
                end
            endcase
        end
    end
    // -----------------------------------------------------------------
    // acknowledge
    // -----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ack_ff <= 1'b0;
        end else if (ctrl_reset) begin
            ack_ff <= 1'b0;
        end else begin
            // rise only on strobe high, fall only on strobe low
            if (request_strobe && (state_ff == ST_NEXT
                                   || (state_ff == ST_IDLE && both_high))) begin
                ack_ff <= 1'b1;
            end else if (!request_strobe && state_ff == ST_ACKED) begin
                ack_ff <= 1'b0;
            end else if (both_low && state_ff == ST_DFLT) begin
                ack_ff <= 1'b0;
            end
        end
    end
    // -----------------------------------------------------------------
    // byte counter
    // -----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= 2'h0;
        end else if (ctrl_reset) begin
            cnt_ff <= 2'h0;
        end else if (state_ff == ST_IDLE && both_high && !dflt_valid_ff) begin
            cnt_ff <= BYTE_COUNT_INIT;
        end else if (state_ff == ST_NEXT && both_high) begin
            // flag set again restarts the count
            cnt_ff <= BYTE_COUNT_INIT;
        end else if (state_ff == ST_ACKED && !request_strobe) begin
            // strobe low takes one byte off the count
            cnt_ff <= cnt_ff - 2'h1;
        end
    end
    // -----------------------------------------------------------------
    // byte storage
    // -----------------------------------------------------------------
    // one byte captured per handshake while no default address is stored, none once one is
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            byte0_ff <= 8'h00;
            byte1_ff <= 8'h00;
            byte2_ff <= 8'h00;
        end else if (!ctrl_reset) begin
            if ((state_ff == ST_IDLE && both_high && !dflt_valid_ff)
                || (state_ff == ST_NEXT && both_high)) begin
                byte0_ff <= addr_byte;
            end else if (state_ff == ST_NEXT && request_strobe) begin
                // later bytes fill by remaining count
                if (cnt_ff == 2'h2) begin
                    byte1_ff <= addr_byte;
                end else begin
                    byte2_ff <= addr_byte;
                end
            end
        end
    end
    // -----------------------------------------------------------------
    // default list address
    // -----------------------------------------------------------------
    // survives controller reset as a stored command result
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dflt_ff <= '0;
            dflt_valid_ff <= 1'b0;
        end else if (dflt_load) begin
            dflt_ff <= dflt_addr_in;
            dflt_valid_ff <= 1'b1;
        end
    end
    // -----------------------------------------------------------------
    // list start
    // -----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            start_ff <= 1'b0;
            laddr_ff <= '0;
        end else begin
            start_ff <= 1'b0;
            if (!ctrl_reset && state_ff == ST_ACKED && !request_strobe
                && cnt_ff == 2'h1) begin
                // last byte done, hand assembled address on
                // nibble, byte, seven bits plus zero
                start_ff <= 1'b1;
                laddr_ff <= join_addr(byte0_ff, byte1_ff, byte2_ff);
            end else if (!ctrl_reset && state_ff == ST_DFLT && both_low) begin
                start_ff <= 1'b1;
                laddr_ff <= dflt_ff;
            end
        end
    end
    // -----------------------------------------------------------------
    // host interrupt issued flag
    // -----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            issued_ff <= 1'b0;
        end else if (host_irq_event && irq_enable) begin
            issued_ff <= 1'b1;
        end else if (!irq_enable) begin
            // enable low clears the issued flag
            issued_ff <= 1'b0;
        end
    end
    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    a_ack_rise_strobe: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(ack_ff) |-> $past(request_strobe))
        else $error("ack rose without strobe high");
    a_ack_fall_strobe: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(ack_ff) && !$past(ctrl_reset) |-> !$past(request_strobe))
        else $error("ack fell with strobe high");
    a_first_byte_take: assert property (@(posedge mclk) disable iff (!rstn)
        state_ff == ST_IDLE && both_high && !dflt_valid_ff && !ctrl_reset
        |=> busy && ack_ff && cnt_ff == 2'h3 && byte0_ff == $past(addr_byte))
        else $error("first byte not taken");
    a_count_decrement: assert property (@(posedge mclk) disable iff (!rstn)
        state_ff == ST_ACKED && !request_strobe && !ctrl_reset
        |=> !ack_ff && cnt_ff == $past(cnt_ff) - 2'h1)
        else $error("count not decremented");
    a_restart_first: assert property (@(posedge mclk) disable iff (!rstn)
        state_ff == ST_NEXT && both_high && !ctrl_reset
        |=> cnt_ff == 2'h3 && ack_ff && state_ff == ST_ACKED)
        else $error("restart not honoured");
    a_list_start: assert property (@(posedge mclk) disable iff (!rstn)
        state_ff == ST_ACKED && !request_strobe && cnt_ff == 2'h1 && !ctrl_reset
        |=> list_start && list_addr[0] == 1'b0 && state_ff == ST_EXEC)
        else $error("list not started");
    a_default_start: assert property (@(posedge mclk) disable iff (!rstn)
        state_ff == ST_IDLE && both_high && dflt_valid_ff && !ctrl_reset
        ##1 both_low && !ctrl_reset |=> list_start && list_addr == dflt_ff)
        else $error("default start wrong");
    a_default_hold: assert property (@(posedge mclk) disable iff (!rstn)
        state_ff == ST_DFLT && !both_low && !ctrl_reset |=> ack_ff && busy)
        else $error("default ack dropped early");
    a_reset_busy: assert property (@(posedge mclk) disable iff (!rstn)
        ctrl_reset |=> busy && !ack_ff)
        else $error("reset bit not holding controller");
    a_issued_clear: assert property (@(posedge mclk) disable iff (!rstn)
        !irq_enable |=> !issued_ff)
        else $error("issued flag not cleared");
endmodule
`default_nettype wire

// >>> cmdlist_pkg.sv
// constants, types and helpers for the command list address handshake port
`default_nettype none
package cmdlist_pkg;
    // -----------------------------------------------------------------
    // bus geometry
    // -----------------------------------------------------------------
    localparam int unsigned CRU_AW = 12;           // bit address width
    localparam logic [11:0] SW_BASE = 12'h210;     // software base of bit 0
    localparam logic [4:0] USED_LO = 5'h08;        // first used block position
    localparam logic [4:0] USED_HI = 5'h17;        // last used block position
    // hardware block base: software address halved, less reserved positions
    localparam logic [11:0] BLOCK_BASE_DEF = (SW_BASE >> 1) - 12'h008;
    // -----------------------------------------------------------------
    // bit positions inside the sixteen used positions
    // -----------------------------------------------------------------
    localparam logic [3:0] POS_BYTE_MSB = 4'h7;
    localparam logic [3:0] POS_FIRST = 4'h8;
    localparam logic [3:0] POS_STROBE = 4'ha;
    localparam logic [3:0] POS_ACK = 4'hb;
    localparam logic [3:0] POS_BUSY = 4'hc;
    localparam logic [3:0] POS_IE = 4'hd;
    localparam logic [3:0] POS_RESET = 4'he;
    localparam logic [3:0] POS_ISSUED = 4'hf;
    // -----------------------------------------------------------------
    // handshake and timing
    // -----------------------------------------------------------------
    localparam logic [1:0] BYTE_COUNT_INIT = 2'h3;
    localparam int unsigned LIST_AW = 20;          // byte address, lsb zero when assembled from bytes, default address passed as stored
    localparam int unsigned CLK_MHZ = 10;
    localparam int unsigned SELFTEST_US = 1000;    // self-test duration
    localparam int unsigned SELFTEST_CYC = SELFTEST_US * CLK_MHZ;
    // controller sequencing states
    typedef enum logic [2:0] {
        ST_TEST, ST_IDLE, ST_ACKED, ST_NEXT, ST_DFLT, ST_EXEC
    } ctl_state_t;
    // build the list byte address from the three received bytes
    function automatic logic [LIST_AW-1:0] join_addr(input logic [7:0] b0,
                                                     input logic [7:0] b1,
                                                     input logic [7:0] b2);
        join_addr = {b0[3:0], b1, b2[7:1], 1'b0};
    endfunction
endpackage
`default_nettype wire

// >>> cru_bit_port.sv
// bit-addressed register port: decode, output bit latches, input bit read
`default_nettype none
module cru_bit_port #(
    parameter logic [cmdlist_pkg::CRU_AW-1:0] BLOCK_BASE = cmdlist_pkg::BLOCK_BASE_DEF
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [cmdlist_pkg::CRU_AW-1:0] cru_addr,
    input wire logic cru_wr,
    input wire logic cru_wdata,
    input wire logic st_ack,
    input wire logic st_busy,
    input wire logic st_issued,
    output logic cru_rdata,
    output logic [7:0] addr_byte,
    output logic first_flag,
    output logic strobe,
    output logic irq_enable,
    output logic ctrl_reset
);
    import cmdlist_pkg::*;
    // -----------------------------------------------------------------
    // decode
    // -----------------------------------------------------------------
    logic blk_hit; // address inside the 32-position block
    logic [4:0] blk_pos; // position inside the block
    logic used_hit; // one of the middle sixteen positions
    logic [3:0] pos; // position relative to bit 0
    logic [15:0] in_bits; // readable positions
    logic [4:0] rel_pos; // position after removing the reserved low eight
    // only the middle sixteen of the block answer
    assign blk_hit = (cru_addr[CRU_AW-1:5] == BLOCK_BASE[CRU_AW-1:5]);
    assign blk_pos = cru_addr[4:0];
    assign used_hit = blk_hit && (blk_pos >= USED_LO) && (blk_pos <= USED_HI);
    // position 0 sits eight above the block base
    assign rel_pos = blk_pos - USED_LO;
    assign pos = rel_pos[3:0];
    // -----------------------------------------------------------------
    // output bit latches
    // -----------------------------------------------------------------
    // byte and first-byte flag bits latched from host writes
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            addr_byte <= 8'h00;
            first_flag <= 1'b0;
            strobe <= 1'b0;
            irq_enable <= 1'b0;
            ctrl_reset <= 1'b0;
        end else if (cru_wr && used_hit) begin
            if (pos <= POS_BYTE_MSB) begin
                addr_byte[pos[2:0]] <= cru_wdata;
            end
            if (pos == POS_FIRST) begin
                first_flag <= cru_wdata;
            end
            if (pos == POS_STROBE) begin
                strobe <= cru_wdata;
            end
            if (pos == POS_IE) begin
                irq_enable <= cru_wdata;
            end
            if (pos == POS_RESET) begin
                ctrl_reset <= cru_wdata;
            end
        end
    end
    // -----------------------------------------------------------------
    // input bit read
    // -----------------------------------------------------------------
    // status bits at their positions, all others zero
    always_comb begin
        in_bits = 16'h0000;
        in_bits[POS_ACK] = st_ack;
        in_bits[POS_BUSY] = st_busy;
        in_bits[POS_ISSUED] = st_issued;
    end
    // registered read, one cycle after the address is presented
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cru_rdata <= 1'b0;
        end else begin
            cru_rdata <= used_hit && in_bits[pos];
        end
    end
endmodule
`default_nettype wire

// >>> host_model.sv
// host processor model that drives the bit-addressed port
`default_nettype none
module host_model
    import cmdlist_pkg::*;
(
    input wire logic mclk,
    input wire logic cru_rdata,
    output logic [11:0] cru_addr,
    output logic cru_wr,
    output logic cru_wdata
);
    int n_to; // handshake waits that ran out
    initial begin
        cru_addr = 12'h000;
        cru_wr = 1'b0;
        cru_wdata = 1'b0;
        n_to = 0;
    end
    // write one used position; data line then shows the inverse
    task automatic wbit(input logic [4:0] pos, input logic v);
        @(posedge mclk);
        cru_addr <= BLOCK_BASE_DEF + 12'h008 + {7'h00, pos};
        cru_wr <= 1'b1;
        cru_wdata <= v;
        @(posedge mclk);
        cru_wr <= 1'b0;
        cru_wdata <= ~v;
    endtask
    // read one position, one cycle of latency
    task automatic rbit(input logic [4:0] pos, output logic v);
        @(posedge mclk);
        cru_addr <= BLOCK_BASE_DEF + 12'h008 + {7'h00, pos};
        @(posedge mclk);
        #1 v = cru_rdata;
    endtask
    // poll a position under a bounded count
    task automatic wait_bit(input logic [4:0] pos, input logic v);
        logic b;
        for (int i = 0; i < 100; i++) begin
            rbit(pos, b);
            if (b === v) return;
        end
        n_to++;
    endtask
    task automatic hs(input logic [7:0] byt, input logic first);
        if (first) wbit(5'h08, 1'b1);
        for (int i = 0; i < 8; i++) wbit(i[4:0], byt[i]);
        wbit(5'h0a, 1'b1);
        wait_bit(5'h0b, 1'b1);
        wbit(5'h0a, 1'b0);
        if (first) wbit(5'h08, 1'b0);
        wait_bit(5'h0b, 1'b0);
    endtask
    task automatic xfer(input logic [19:0] a);
        wait_bit(5'h0c, 1'b0);
        wait_bit(5'h0b, 1'b0);
        hs({4'h0, a[19:16]}, 1'b1);
        hs(a[15:8], 1'b0);
        hs({a[7:1], 1'b0}, 1'b0);
    endtask
endmodule
`default_nettype wire

// >>> command_list_address_handshake_test.sv
// self-checking bench for the command list address handshake port
`default_nettype none
module command_list_address_handshake_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rstn, cru_wr, cru_wdata, cru_rdata, irq_line, list_start;
    logic exec_done, dflt_load, host_irq_event, host_irq, busy, in_rst, b;
    logic [11:0] cru_addr;
    logic [19:0] list_addr, dflt_addr_in, got_addr;
    int n_fail = 0;
    int total_checks = 0;
    int n_start = 0;
    int s;
    cmdlist_handshake #(.SELFTEST_CYCLES(8)) dut (.mclk(mclk), .rstn(rstn),
        .cru_addr(cru_addr), .cru_wr(cru_wr), .cru_wdata(cru_wdata), .cru_rdata(cru_rdata),
        .controller_irq_line(irq_line), .list_start(list_start), .list_addr(list_addr),
        .exec_done(exec_done), .dflt_load(dflt_load), .dflt_addr_in(dflt_addr_in),
        .host_irq_event(host_irq_event), .host_irq(host_irq), .busy(busy),
        .ctrl_in_reset(in_rst));
    host_model host (.mclk(mclk), .cru_rdata(cru_rdata), .cru_addr(cru_addr),
        .cru_wr(cru_wr), .cru_wdata(cru_wdata));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // count list starts and keep the address they carry
    always @(posedge mclk) begin
        if (list_start === 1'b1) begin
            n_start <= n_start + 1;
            got_addr <= list_addr;
        end
    end
    task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic chk_bit(input string what, input logic [4:0] pos, input logic exp);
        host.rbit(pos, b);
        chk(what, {19'h0, b}, {19'h0, exp});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic selftest;
        tick(5);
        chk("busy test", {19'h0, busy}, 20'h1);
        tick(6);
        chk_bit("busy bit", 5'h0c, 1'b0);
    endtask
    task automatic finish_exec;
        chk("busy run", {19'h0, busy}, 20'h1);
        @(posedge mclk);
        exec_done <= 1'b1;
        @(posedge mclk);
        exec_done <= 1'b0;
        tick(1);
        chk("busy done", {19'h0, busy}, 20'h0);
    endtask
    task automatic t_refused;
        chk_bit("unused", 5'h09, 1'b0);
        chk_bit("reserved", 5'h10, 1'b0);
        host.wbit(5'h0b, 1'b1);
        host.wbit(5'h0a, 1'b1);
        #1;
        chk("irq line", {19'h0, irq_line}, 20'h1);
        tick(3);
        chk_bit("ack no flag", 5'h0b, 1'b0);
        host.wbit(5'h0a, 1'b0);
    endtask
    task automatic t_addr(input logic [7:0] a0, input logic [19:0] exp);
        s = n_start;
        if (a0 == 8'h00) host.xfer(exp);
        else begin
            // restart with a new first byte
            host.hs(a0, 1'b1);
            host.hs(8'hfa, 1'b1);
            host.hs(8'h12, 1'b0);
            host.hs(8'h35, 1'b0);
        end
        chk("starts", 20'(n_start - s), 20'h1);
        chk("list addr", got_addr, exp);
        finish_exec;
    endtask
    task automatic t_irq;
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk);
            host_irq_event <= 1'b1;
            @(posedge mclk);
            host_irq_event <= 1'b0;
            tick(1);
            chk("issued", {19'h0, host_irq}, 20'(i));
            host.wbit(5'h0d, 1'b1);
        end
        chk_bit("issued bit", 5'h0f, 1'b1);
        host.wbit(5'h0d, 1'b0);
        tick(1);
        chk("issued clr", {19'h0, host_irq}, 20'h0);
    endtask
    task automatic t_default;
        @(posedge mclk);
        dflt_addr_in <= 20'h2468a;
        dflt_load <= 1'b1;
        @(posedge mclk);
        dflt_load <= 1'b0;
        s = n_start;
        host.wbit(5'h08, 1'b1);
        host.wbit(5'h0a, 1'b1);
        host.wait_bit(5'h0b, 1'b1);
        host.wbit(5'h0a, 1'b0);
        chk_bit("ack held", 5'h0b, 1'b1);
        host.wbit(5'h08, 1'b0);
        host.wait_bit(5'h0b, 1'b0);
        chk("dflt addr", got_addr, 20'h2468a);
        finish_exec;
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        rstn = 1'b0;
        exec_done = 1'b0;
        dflt_load = 1'b0;
        dflt_addr_in = 20'h00000;
        host_irq_event = 1'b0;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        #1;
        selftest;
        t_refused;
        t_addr(8'h00, 20'h1fe80);
        t_addr(8'h03, 20'ha1234);
        t_irq;
        host.wbit(5'h0e, 1'b1);
        tick(1);
        chk("in reset", {18'h0, in_rst, busy}, 20'h3);
        host.wbit(5'h0e, 1'b0);
        selftest;
        t_default;
        chk("timeouts", 20'(host.n_to), 20'h0);
        end_sim;
    end
    initial begin
        #1000000;
        n_fail++;
        end_sim;
    end
endmodule
`default_nettype wire
